// file: srw_pkg.sv
// shared constants, state type and check-code step for the serial read/write command slave
package srw_pkg;
  typedef logic [16:0] pos_t;
  // framing characters and codes
  localparam logic [7:0] SOM_BYTE = 8'h1b;
  localparam logic [7:0] CMD_X = 8'h58;
  localparam logic [7:0] CMD_BUF = 8'h54;
  localparam logic [7:0] EOB_BYTE = 8'h17;
  localparam logic [7:0] REQ_READ = 8'h01;
  localparam logic [7:0] REQ_WRITE = 8'h02;
  localparam logic [7:0] RESP_FLAG = 8'h80;
  localparam logic [7:0] BCAST_BYTE = 8'hff;
  // segment selectors and their tables
  localparam logic [7:0] SEG_R_WORD = 8'h08;
  localparam logic [7:0] SEG_Q_BIT = 8'h48;
  localparam logic [7:0] SEG_I_BIT = 8'h46;
  localparam logic [7:0] SEG_M_BIT = 8'h4c;
  // error status
  localparam logic [7:0] ERR_MAJOR = 8'h04;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_SEG = 8'h01;
  localparam logic [7:0] ERR_RANGE = 8'h02;
  localparam logic [7:0] ERR_LEN = 8'h03;
  localparam logic [7:0] ERR_CODE = 8'h04;
  localparam logic [7:0] ERR_FIELD = 8'h05;
  // byte positions, one based
  localparam pos_t POS_SOM = 17'd1;
  localparam pos_t POS_CMD = 17'd2;
  localparam pos_t POS_ID_FIRST = 17'd3;
  localparam pos_t POS_ID_LAST = 17'd10;
  localparam pos_t POS_CODE = 17'd11;
  localparam pos_t POS_SEL = 17'd12;
  localparam pos_t POS_OFF_LO = 17'd13;
  localparam pos_t POS_OFF_HI = 17'd14;
  localparam pos_t POS_LEN_LO = 17'd15;
  localparam pos_t POS_LEN_HI = 17'd16;
  localparam pos_t POS_WD_LO = 17'd17;
  localparam pos_t POS_WD_HI = 17'd18;
  localparam pos_t POS_REQ_EOB = 17'd19;
  localparam pos_t POS_BLEN_LO = 17'd3;
  localparam pos_t POS_BLEN_HI = 17'd4;
  localparam pos_t BUF_DATA_POS = 17'd5;
  localparam pos_t TRL_BCC_OFS = 17'd5;
  localparam pos_t RSP_CODE = 17'd3;
  localparam pos_t RSP_STAT_LO = 17'd4;
  localparam pos_t RSP_STAT_HI = 17'd5;
  localparam pos_t RSP_MAJOR = 17'd6;
  localparam pos_t RSP_MINOR = 17'd7;
  localparam pos_t RSP_LEN_LO = 17'd8;
  localparam pos_t RSP_LEN_HI = 17'd9;
  localparam pos_t RSP_DATA_POS = 17'd10;
  localparam pos_t STG_BYTES = 17'd1024;
  // size limits
  localparam logic [17:0] MAX_DATA = 18'd1000;
  localparam logic [17:0] TABLE_SPAN = 18'd1024;
  localparam logic [17:0] EMBED_MAX = 18'd2;
  localparam int TBL_AW = 12;
  localparam int STG_AW = 10;
  typedef enum logic [1:0] {S_RECV, S_EXEC, S_COPY, S_SEND} state_e;
  // check-code step: xor the byte in, then rotate left by one
  function automatic logic [7:0] bcc_step(input logic [7:0] acc, input logic [7:0] b);
    logic [7:0] x;
    x = acc ^ b;
    return {x[6:0], x[7]};
  endfunction
endpackage

// file: srw_if.sv
// carriers between the slave and its buffer and byte stores
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

interface byte_mem_if #(parameter int AW = 10);
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport user (output we, output addr, output wdata, input rdata);
  modport store (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: two_entry_buffer.sv
// two-entry buffer with registered head, so a stalled receiver loses no byte
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
  parameter int W = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  byte_stream_if.snk in_s,
  byte_stream_if.src out_s
);
  logic [W-1:0] head;
  logic [W-1:0] tail;
  logic head_v;
  logic tail_v;
  logic push;
  logic pop;

  // ready only while the tail slot is free
  assign in_s.ready = !tail_v;
  assign out_s.valid = head_v;
  assign out_s.data = head;
  assign push = in_s.valid && !tail_v;
  assign pop = head_v && out_s.ready;

  // head is shown to the receiver, tail shifts forward on a pop
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      head_v <= 1'b0;
      tail_v <= 1'b0;
      head <= '0;
      tail <= '0;
    end else if (pop) begin
      if (tail_v) begin
        head <= tail;
        if (push) begin
          tail <= in_s.data;
        end else begin
          tail_v <= 1'b0;
        end
      end else if (push) begin
        head <= in_s.data;
      end else begin
        head_v <= 1'b0;
      end
    end else if (push) begin
      if (!head_v) begin
        head <= in_s.data;
        head_v <= 1'b1;
      end else begin
        tail <= in_s.data;
        tail_v <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: byte_store.sv
// byte-wide single-port store with registered read data
`timescale 1ns/1ps
`default_nettype none
module byte_store #(
  parameter int AW = 10
) (
  input wire logic clock_i,
  byte_mem_if.store port_m
);
  logic [7:0] cells [2**AW];

  // read returns the old contents on a same-address write
  always_ff @(posedge clock_i) begin
    if (port_m.we) begin
      cells[port_m.addr] <= port_m.wdata;
    end
    port_m.rdata <= cells[port_m.addr];
  end
endmodule
`default_nettype wire

// file: serial_rw_slave.sv
// read/write command slave: request parser, table access and response framer
// Notes on behaviour
// - every message opens with 1B
// - second byte is command 58, or 54 on a buffer message
// - bytes 3-10 carry target station identifier
// - request code 01 means read
// - selector byte, offset and length little endian
// - read spare zero, trailer 17, zeros, check
// - read response code 81 in byte three
// - status word then major and minor codes
// - data length then data from byte ten
// - response ends 17, four zeros, check code
// - one contiguous region of one table
// - two bytes or fewer travel embedded
// - longer writes use buffer, embedded data ignored
// - buffered write gets intermediate response first
// - buffer message holds up to 1000 bytes
// - directed write ends with final response
// - data byte aligned, bits at own position
// - own identifier, null only on point-to-point
// - broadcast write accepted, never answered
// - response code is request code plus 80
// - request code 02 means write
// - write response code 82, length zero
// - broadcast identifier is all FF, never answered
`timescale 1ns/1ps
`default_nettype none
module serial_rw_slave (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic [63:0] station_identifier_i,
  input wire logic point_to_point_i,
  input wire logic [15:0] plc_status_i,
  output logic write_done_o
);
  import srw_pkg::*;

  state_e state;
  srw_pkg::pos_t rx_idx, pos, eob_pos, stg_idx, tx_idx, dat_end, dix;
  logic [7:0] rx_bcc, tx_bcc, tx_byte, code, seg, resp_code, resp_minor, own_byte, req_minor;
  logic [15:0] off, len, wd, buf_len;
  logic is_buf, id_own, id_null, id_bc, await_buf, bcast_pend, use_stg, phase;
  logic rx_take, byte_ok, frame_end, frame_good, push, addressed, req_ok, buf_len_ok;
  logic sel_ok, bit_mode;
  logic [1:0] sel_tbl, tbl;
  logic [17:0] start_b, nb;
  logic [9:0] start;
  logic [10:0] n_bytes, cnt, resp_len;
  logic [2:0] id_k;

  byte_stream_if #(.W(8)) tx_in_s ();
  byte_stream_if #(.W(8)) tx_out_s ();
  byte_mem_if #(.AW(STG_AW)) stg_m ();
  byte_mem_if #(.AW(TBL_AW)) tbl_m ();

  two_entry_buffer #(.W(8)) u_txbuf (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_s(tx_in_s.snk),
    .out_s(tx_out_s.src)
  );
  byte_store #(.AW(STG_AW)) u_stage (.clock_i(clock_i), .port_m(stg_m.store));
  byte_store #(.AW(TBL_AW)) u_tables (.clock_i(clock_i), .port_m(tbl_m.store));

  assign tx_data_o = tx_out_s.data;
  assign tx_valid_o = tx_out_s.valid;
  assign tx_out_s.ready = tx_ready_i;

  // receive framing: hunt for the opening byte, check fixed fields and trailer
  assign rx_take = rx_valid_i && rx_ready_o;
  assign pos = rx_idx + 17'd1;
  assign eob_pos = is_buf ? {1'b0, buf_len} + BUF_DATA_POS : POS_REQ_EOB;
  always_comb begin
    byte_ok = 1'b1;
    frame_end = 1'b0;
    if (pos == POS_SOM) begin
      byte_ok = (rx_data_i == SOM_BYTE);
    end else if (pos == POS_CMD) begin
      byte_ok = (rx_data_i == CMD_X) || (rx_data_i == CMD_BUF && await_buf);
    end else if (pos == eob_pos) begin
      byte_ok = (rx_data_i == EOB_BYTE);
    end else if (pos > eob_pos && pos < eob_pos + TRL_BCC_OFS) begin
      byte_ok = (rx_data_i == 8'h00);
    end else if (pos == eob_pos + TRL_BCC_OFS) begin
      frame_end = 1'b1;
    end
  end
  // a failed check code simply restarts the hunt, nothing is answered
  assign frame_good = rx_take && byte_ok && frame_end && (rx_data_i == rx_bcc);

  // byte counter and running check code
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_idx <= '0;
      rx_bcc <= 8'h00;
    end else if (rx_take) begin
      rx_idx <= (byte_ok && !frame_end) ? pos : '0;
      rx_bcc <= bcc_step((pos == POS_SOM) ? 8'h00 : rx_bcc, rx_data_i);
    end
  end

  // identifier byte k sits in bits 8k+7..8k of the station identifier
  assign id_k = pos[2:0] - 3'd3;
  assign own_byte = station_identifier_i[{id_k, 3'b000} +: 8];

  // capture request or buffer header fields
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      is_buf <= 1'b0;
      {id_own, id_null, id_bc} <= 3'b000;
      {code, seg, off, len, wd, buf_len} <= '0;
    end else if (rx_take) begin
      if (pos == POS_CMD) begin
        is_buf <= (rx_data_i == CMD_BUF);
        if (rx_data_i == CMD_X) begin
          {id_own, id_null, id_bc} <= 3'b111;
        end
      end else if (is_buf) begin
        if (pos == POS_BLEN_LO) buf_len[7:0] <= rx_data_i;
        if (pos == POS_BLEN_HI) buf_len[15:8] <= rx_data_i;
      end else if (pos >= POS_ID_FIRST && pos <= POS_ID_LAST) begin
        id_own <= id_own && (rx_data_i == own_byte);
        id_null <= id_null && (rx_data_i == 8'h00);
        id_bc <= id_bc && (rx_data_i == BCAST_BYTE);
      end else begin
        case (pos)
          POS_CODE: code <= rx_data_i;
          POS_SEL: seg <= rx_data_i;
          POS_OFF_LO: off[7:0] <= rx_data_i;
          POS_OFF_HI: off[15:8] <= rx_data_i;
          POS_LEN_LO: len[7:0] <= rx_data_i;
          POS_LEN_HI: len[15:8] <= rx_data_i;
          POS_WD_LO: wd[7:0] <= rx_data_i;
          POS_WD_HI: wd[15:8] <= rx_data_i;
          default: ;
        endcase
      end
    end
  end

  // selector decode; bit mode counts bits, word mode two bytes per element
  always_comb begin
    sel_ok = 1'b1;
    bit_mode = 1'b1;
    sel_tbl = 2'd0;
    case (seg)
      SEG_R_WORD: bit_mode = 1'b0;
      SEG_Q_BIT: sel_tbl = 2'd1;
      SEG_I_BIT: sel_tbl = 2'd2;
      SEG_M_BIT: sel_tbl = 2'd3;
      default: sel_ok = 1'b0;
    endcase
  end
  // bit elements keep their own bit position, so whole bytes around them move
  assign start_b = bit_mode ? {5'b0, off[15:3]} : {1'b0, off, 1'b0};
  assign nb = bit_mode ? (({15'b0, off[2:0]} + {2'b0, len} + 18'd7) >> 3) : {1'b0, len, 1'b0};
  always_comb begin
    if (code != REQ_READ && code != REQ_WRITE) begin
      req_minor = ERR_CODE;
    end else if (!sel_ok) begin
      req_minor = ERR_SEG;
    end else if (nb == 18'd0 || nb > MAX_DATA || start_b + nb > TABLE_SPAN) begin
      req_minor = ERR_RANGE;
    end else if (code == REQ_READ && wd != 16'h0000) begin
      req_minor = ERR_FIELD;
    end else begin
      req_minor = ERR_NONE;
    end
  end
  assign req_ok = (req_minor == ERR_NONE);
  assign addressed = id_own || (id_null && point_to_point_i);
  assign buf_len_ok = (buf_len == {5'b0, n_bytes});

  // command sequencing
  always_ff @(posedge clock_i) begin
    write_done_o <= 1'b0;
    if (rst_i) begin
      state <= S_RECV;
      rx_ready_o <= 1'b1;
      {await_buf, bcast_pend, use_stg} <= 3'b000;
      {tbl, start, n_bytes, cnt, resp_len} <= '0;
      resp_code <= 8'h00;
      resp_minor <= ERR_NONE;
    end else begin
      case (state)
        S_RECV: if (frame_good) begin
          state <= S_EXEC;
          rx_ready_o <= 1'b0;
        end
        S_EXEC: begin
          cnt <= '0;
          resp_len <= '0;
          state <= S_RECV;
          rx_ready_o <= 1'b1;
          if (is_buf) begin
            await_buf <= 1'b0;
            if (buf_len_ok) begin
              use_stg <= 1'b1;
              state <= S_COPY;
              rx_ready_o <= 1'b0;
            end else if (!bcast_pend) begin
              resp_minor <= ERR_LEN;
              state <= S_SEND;
              rx_ready_o <= 1'b0;
            end else begin
              bcast_pend <= 1'b0;
            end
          end else begin
            tbl <= sel_tbl;
            start <= start_b[9:0];
            n_bytes <= nb[10:0];
            resp_code <= code | RESP_FLAG;
            resp_minor <= req_minor;
            use_stg <= 1'b0;
            await_buf <= 1'b0;
            bcast_pend <= 1'b0;
            if (id_bc) begin
              // broadcast: only a good write is carried out, silently
              if (code == REQ_WRITE && req_ok) begin
                bcast_pend <= 1'b1;
                if (nb <= EMBED_MAX) begin
                  state <= S_COPY;
                  rx_ready_o <= 1'b0;
                end else begin
                  await_buf <= 1'b1;
                end
              end
            end else if (addressed) begin
              state <= S_SEND;
              rx_ready_o <= 1'b0;
              if (req_ok && code == REQ_READ) begin
                resp_len <= nb[10:0];
              end else if (req_ok && nb <= EMBED_MAX) begin
                state <= S_COPY;
              end else if (req_ok) begin
                await_buf <= 1'b1;
              end
            end
          end
        end
        S_COPY: begin
          cnt <= cnt + 11'd1;
          if (cnt == n_bytes) begin
            write_done_o <= 1'b1;
            bcast_pend <= 1'b0;
            state <= bcast_pend ? S_RECV : S_SEND;
            rx_ready_o <= bcast_pend;
          end
        end
        S_SEND: if (push && tx_idx == dat_end + 17'd1 + TRL_BCC_OFS) begin
          state <= S_RECV;
          rx_ready_o <= 1'b1;
        end
        default: begin
          state <= S_RECV;
          rx_ready_o <= 1'b1;
        end
      endcase
    end
  end

  // staging store takes buffer data until the check code proves it good
  assign stg_idx = pos - BUF_DATA_POS;
  assign stg_m.we = rx_take && is_buf && pos >= BUF_DATA_POS && pos < eob_pos &&
                    stg_idx < STG_BYTES;
  assign stg_m.addr = (state == S_COPY) ? cnt[9:0] : stg_idx[9:0];
  assign stg_m.wdata = rx_data_i;

  // table store: one byte per copy step, read ahead for responses
  assign dix = tx_idx - RSP_DATA_POS;
  assign tbl_m.we = (state == S_COPY) && (cnt != 11'd0);
  assign tbl_m.addr = (state == S_COPY) ? {tbl, start + cnt[9:0] - 10'd1} : {tbl, start + dix[9:0]};
  // embedded data is used only when no buffer follows
  assign tbl_m.wdata = use_stg ? stg_m.rdata : ((cnt == 11'd1) ? wd[7:0] : wd[15:8]);

  // response bytes by position
  assign dat_end = RSP_DATA_POS - 17'd1 + {6'b0, resp_len};
  always_comb begin
    tx_byte = 8'h00;
    if (tx_idx == POS_SOM) begin
      tx_byte = SOM_BYTE;
    end else if (tx_idx == POS_CMD) begin
      tx_byte = CMD_X;
    end else if (tx_idx == RSP_CODE) begin
      tx_byte = resp_code;
    end else if (tx_idx == RSP_STAT_LO) begin
      tx_byte = plc_status_i[7:0];
    end else if (tx_idx == RSP_STAT_HI) begin
      tx_byte = plc_status_i[15:8];
    end else if (tx_idx == RSP_MAJOR) begin
      tx_byte = (resp_minor != ERR_NONE) ? ERR_MAJOR : 8'h00;
    end else if (tx_idx == RSP_MINOR) begin
      tx_byte = resp_minor;
    end else if (tx_idx == RSP_LEN_LO) begin
      tx_byte = resp_len[7:0];
    end else if (tx_idx == RSP_LEN_HI) begin
      tx_byte = {5'b0, resp_len[10:8]};
    end else if (tx_idx <= dat_end) begin
      tx_byte = tbl_m.rdata;
    end else if (tx_idx == dat_end + 17'd1) begin
      tx_byte = EOB_BYTE;
    end else if (tx_idx == dat_end + 17'd1 + TRL_BCC_OFS) begin
      tx_byte = tx_bcc;
    end
  end

  // two cycles per byte: one to settle the table read, one to offer it;
  // halves throughput but avoids a read pipeline around the stall
  assign push = (state == S_SEND) && phase && tx_in_s.ready;
  assign tx_in_s.valid = (state == S_SEND) && phase;
  assign tx_in_s.data = tx_byte;
  always_ff @(posedge clock_i) begin
    if (rst_i || state != S_SEND) begin
      tx_idx <= POS_SOM;
      phase <= 1'b0;
      tx_bcc <= 8'h00;
    end else if (!phase) begin
      phase <= 1'b1;
    end else if (tx_in_s.ready) begin
      phase <= 1'b0;
      tx_idx <= tx_idx + 17'd1;
      tx_bcc <= bcc_step(tx_bcc, tx_byte);
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence good_frame_s;
    frame_good;
  endsequence
  sequence buffered_write_s;
    state == S_EXEC && !is_buf && addressed && !id_bc && code == REQ_WRITE && req_ok &&
      nb > EMBED_MAX;
  endsequence

  frame_to_exec_a: assert property (good_frame_s |=> state == S_EXEC && !rx_ready_o)
    else $error("good frame not executed");
  som_first_a: assert property (push && tx_idx == POS_SOM |-> tx_in_s.data == 8'h1b)
    else $error("response does not open with 1B");
  cmd_second_a: assert property (push && tx_idx == POS_CMD |-> tx_in_s.data == 8'h58)
    else $error("second response byte not 58");
  resp_code_a: assert property (push && tx_idx == RSP_CODE |-> tx_in_s.data == (code | 8'h80))
    else $error("response code not request code with top bit");
  write_len_zero_a: assert property (push && tx_idx == RSP_LEN_LO && code == REQ_WRITE
      |-> tx_in_s.data == 8'h00)
    else $error("write response length not zero");
  trailer_eob_a: assert property (push && tx_idx == dat_end + 17'd1 |-> tx_in_s.data == 8'h17)
    else $error("trailer does not start with 17");
  bcast_quiet_a: assert property (state == S_EXEC && !is_buf && id_bc
      |=> (state != S_SEND)[*3])
    else $error("broadcast request answered");
  bad_bcc_drop_a: assert property (rx_take && byte_ok && frame_end && rx_data_i != rx_bcc
      |=> state == S_RECV && rx_idx == 17'd0)
    else $error("message with bad check code kept");
  interm_resp_a: assert property (buffered_write_s |=> state == S_SEND && await_buf)
    else $error("no intermediate response to buffered write");
  null_ignore_a: assert property (state == S_EXEC && !is_buf && !id_own && !id_bc && id_null &&
      !point_to_point_i |=> state == S_RECV)
    else $error("null identifier accepted on multidrop");
  copy_end_a: assert property (state == S_COPY && cnt == n_bytes
      |=> state != S_COPY && write_done_o)
    else $error("table copy did not end on length");
endmodule
`default_nettype wire

// file: remote_master_model.sv
// remote master model: frames requests and buffer messages, takes response bytes
`timescale 1ns/1ps
`default_nettype none
module remote_master_model (
  input wire logic clock_i,
  input wire logic rst_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic tx_ready_o,
  input wire logic stall_i
);
  logic [7:0] send_q[$];
  // check code: xor in, rotate left one
  function automatic logic [7:0] chk(input logic [7:0] q[$]);
    logic [7:0] a;
    logic [7:0] x;
    a = 8'h00;
    foreach (q[i]) begin
      x = a ^ q[i];
      a = {x[6:0], x[7]};
    end
    return a;
  endfunction
  // request frame, bad flips the check code on purpose
  task automatic request(input logic [63:0] id, input logic [7:0] code, sel,
      input logic [15:0] off, len, wd, input logic bad);
    logic [7:0] f[$];
    f = {8'h1b, 8'h58};
    for (int i = 0; i < 8; i++) f.push_back(id[8*i +: 8]);
    f = {f, code, sel, off[7:0], off[15:8], len[7:0], len[15:8]};
    f = {f, wd[7:0], wd[15:8]};
    f = {f, 8'h17, 8'h00, 8'h00, 8'h00, 8'h00};
    f.push_back(chk(f) ^ {7'h00, bad});
    send_q = {send_q, f};
  endtask
  // buffer message, queued at once; the caller settles until the intermediate answer is in
  task automatic buffer(input logic [7:0] d[$]);
    logic [7:0] f[$];
    logic [15:0] n;
    n = 16'(d.size());
    f = {8'h1b, 8'h54, n[7:0], n[15:8], d};
    f = {f, 8'h17, 8'h00, 8'h00, 8'h00, 8'h00};
    f.push_back(chk(f));
    send_q = {send_q, f};
  endtask
  // hold each byte until taken; idle data inverts so a stale byte never repeats
  always @(posedge clock_i) begin
    if (rst_i) begin
      rx_valid_o <= 1'b0;
      rx_data_o <= 8'h00;
    end else begin
      if (rx_valid_o && rx_ready_i) void'(send_q.pop_front());
      if (send_q.size() != 0) begin
        rx_valid_o <= 1'b1;
        rx_data_o <= send_q[0];
      end else begin
        rx_valid_o <= 1'b0;
        rx_data_o <= ~rx_data_o;
      end
    end
    tx_ready_o <= stall_i ? ($urandom_range(0, 3) == 0) : 1'b1;
  end
endmodule
`default_nettype wire

// file: serial_rw_slave_test.sv
// self-checking bench for the read/write command slave
`timescale 1ns/1ps
`default_nettype none
module serial_rw_slave_test;
  import srw_pkg::*;
  localparam int BCAST_DELAY = 50;
  localparam logic [7:0] ECODE[5] = '{8'h01, 8'h01, 8'h03, 8'h01, 8'h02};
  localparam logic [7:0] ESEL[5] = '{8'h99, 8'h08, 8'h08, 8'h08, 8'h08};
  localparam logic [15:0] ELEN[5] = '{16'h0001, 16'h0000, 16'h0001, 16'h0001, 16'h01f5};
  localparam logic [15:0] EWD[5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000};
  localparam logic [7:0] EMIN[5] = '{ERR_SEG, ERR_RANGE, ERR_CODE, ERR_FIELD, ERR_RANGE};
  localparam logic [7:0] SELS[4] = '{8'h08, 8'h48, 8'h46, 8'h4c};
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic rx_valid, rx_ready, tx_valid, tx_ready, done;
  logic ptp = 1'b0;
  logic stall = 1'b0;
  logic [7:0] rx_data, tx_data;
  logic [63:0] sid;
  logic [63:0] qid[4];
  logic [15:0] status, w;
  logic [7:0] exp_q[$];
  logic [7:0] d[$];
  logic [7:0] e[$];
  int n_fail, samples_checked, dones, exp_dones;
  always #4 clock_i = ~clock_i;
  serial_rw_slave dut (.clock_i(clock_i), .rst_i(rst_i), .rx_data_i(rx_data),
    .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
    .tx_ready_i(tx_ready), .station_identifier_i(sid), .point_to_point_i(ptp),
    .plc_status_i(status), .write_done_o(done));
  remote_master_model m (.clock_i(clock_i), .rst_i(rst_i), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .tx_ready_o(tx_ready), .stall_i(stall));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (exp !== got) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // note the whole response the slave owes
  task automatic expect_rsp(input logic [7:0] code, minor, input logic [7:0] dat[$]);
    logic [7:0] r[$];
    logic [15:0] n;
    n = 16'(dat.size());
    r = {8'h1b, 8'h58, code, status[7:0], status[15:8]};
    r = {r, (minor == ERR_NONE) ? 8'h00 : ERR_MAJOR, minor, n[7:0], n[15:8], dat};
    r = {r, 8'h17, 8'h00, 8'h00, 8'h00, 8'h00};
    r.push_back(m.chk(r));
    exp_q = {exp_q, r};
  endtask
  // wait until all sent and answered, then a fixed quiet spell
  task automatic settle(input int cycles);
    int t;
    t = 0;
    while ((m.send_q.size() != 0 || exp_q.size() != 0 || rx_ready !== 1'b1) && t < 20000) begin
      @(posedge clock_i);
      t++;
    end
    // a hung exchange would otherwise leave its notes unchecked
    if (t >= 20000) begin
      n_fail++;
      $display("[FAIL] settle expected idle seen busy");
    end
    repeat (cycles) @(posedge clock_i);
  endtask
  // any byte without a note is a mismatch, so silent cases are covered too
  always @(posedge clock_i) begin
    if (done === 1'b1) dones++;
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      check("tx_data", exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx, tx_data);
  end
  initial begin
    #(8 * 60000);
    n_fail++;
    give_verdict();
  end
  initial begin
    void'($urandom(98));
    sid = {$urandom(), $urandom()};
    sid[7:0] = 8'h5a; // keeps own id clear of all-zero and all-ones
    status = 16'($urandom());
    qid = '{'1, ~sid, 64'h0, sid};
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    ptp <= 1'b1;
    // embedded write then read back, every table; null id on the Q bit table
    foreach (SELS[i]) begin
      w = 16'($urandom());
      m.request(i == 1 ? 64'h0 : sid, REQ_WRITE, SELS[i], 16'h0012, 16'h0001, w, 1'b0);
      exp_dones++;
      expect_rsp(8'h82, ERR_NONE, e);
      settle(2);
      if (i == 0) d = {w[7:0], w[15:8]};
      else d = {w[7:0]};
      m.request(sid, REQ_READ, SELS[i], i == 0 ? 16'h0012 : 16'h0010, i == 0 ? 16'h1 : 16'h8,
        16'h0000, 1'b0);
      expect_rsp(8'h81, ERR_NONE, d);
      settle(2);
    end
    ptp <= 1'b0;
    // buffered write under receiver stall; embedded field must be ignored
    stall <= 1'b1;
    d = {};
    repeat (6) d.push_back(8'($urandom()));
    m.request(sid, REQ_WRITE, SEG_R_WORD, 16'h0002, 16'h0003, 16'hbeef, 1'b0);
    expect_rsp(8'h82, ERR_NONE, e);
    settle(4);
    m.buffer(d);
    exp_dones++;
    expect_rsp(8'h82, ERR_NONE, e);
    settle(2);
    m.request(sid, REQ_READ, SEG_R_WORD, 16'h0002, 16'h0003, 16'h0000, 1'b0);
    expect_rsp(8'h81, ERR_NONE, d);
    settle(2);
    // buffer length that disagrees with the request is refused with an error
    m.request(sid, REQ_WRITE, SEG_R_WORD, 16'h0040, 16'h0002, 16'h0000, 1'b0);
    expect_rsp(8'h82, ERR_NONE, e);
    settle(4);
    m.buffer(e);
    expect_rsp(8'h82, ERR_LEN, e);
    settle(2);
    stall <= 1'b0;
    // error answers
    foreach (ECODE[i]) begin
      m.request(sid, ECODE[i], ESEL[i], 16'h0000, ELEN[i], EWD[i], 1'b0);
      expect_rsp(ECODE[i] | 8'h80, EMIN[i], e);
      settle(2);
    end
    // broadcast write is applied but never answered
    w = 16'($urandom());
    m.request('1, REQ_WRITE, SEG_R_WORD, 16'h0030, 16'h0001, w, 1'b0);
    exp_dones++;
    settle(BCAST_DELAY);
    // broadcast read, foreign id, null id off point-to-point, bad check code
    foreach (qid[i]) begin
      m.request(qid[i], REQ_READ, SEG_R_WORD, 16'h0030, 16'h0001, 16'h0000, 1'(i == 3));
      settle(40);
    end
    m.request(sid, REQ_READ, SEG_R_WORD, 16'h0030, 16'h0001, 16'h0000, 1'b0);
    d = {w[7:0], w[15:8]};
    expect_rsp(8'h81, ERR_NONE, d);
    settle(4);
    check("write_done_o count", 8'(exp_dones), 8'(dones));
    check("rx_ready_o", 8'h01, {7'h00, rx_ready});
    give_verdict();
  end
endmodule
`default_nettype wire
